/* File: hdl/eight_bit_timer_prescaler.sv */
// Eight-bit timer/counter with a prescaler shared exclusively with the watchdog.
// Assumes one clk_i period is one instruction cycle and that sleep and watchdog clear
// come from core logic on the same clock; the count pin is asynchronous.
//
// Overview of operation
// - Clock source clear and no prescaler: count increments every instruction cycle.
// - A write to the count suppresses counting for the next two cycles.
// - Clock source set counts pin edges; polarity bit clear rising, set falling.
// - The count pin is synchronised before use, adding a fixed delay.
// - Wrap from FFh to 00h sets the overflow flag.
// - Interrupt request is the overflow flag gated by its enable bit.
// - Sleep stops the timer, so no overflow can occur while asleep.
// - One eight-bit prescaler serves either the timer or the watchdog.
// - Prescaler count has no read or write path; only its setup shows.
// - Assignment and rate sit in option bits 3:0; timer ratios 1:2 to 1:256.
// - Assignment set routes the prescaler to the watchdog, ratios 1:1 to 1:128.
// - With timer assignment, a count write clears the prescaler, assignment untouched.
// - With watchdog assignment, watchdog clear resets prescaler and watchdog.
// - Assignment may change at any time without reset or halt.
`timescale 1ns/100ps

module eight_bit_timer_prescaler (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [tmr_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic ext_count_pin_i,
    input wire logic sleep_i,
    input wire logic watchdog_tick_i,
    input wire logic watchdog_clear_instruction_i,
    output logic watchdog_post_tick_o,
    output logic watchdog_reset_o,
    output logic irq_o
);

    typedef struct packed {
        logic [7:0] timer_count;
        logic [7:0] option_control;
        logic overflow_flag;
        logic overflow_int_enable;
        logic [7:0] prescaler;
        logic [1:0] inhibit;
        logic ext_prev;
        logic assign_prev;
        logic [7:0] rdata;
        logic watchdog_post;
        logic watchdog_reset;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic ext_level;
    logic timer_wr;
    logic intctl_wr;
    logic option_wr;
    logic rise;
    logic fall;
    logic src_tick;
    logic gated_tick;
    logic to_watchdog;
    logic [2:0] rate;
    logic [7:0] timer_mask;
    logic [7:0] watchdog_mask;
    logic [7:0] pre_mask;
    logic pre_in;
    logic pre_wrap;
    logic pre_clear;
    logic timer_inc;
    logic [7:0] intctl_view;

    pin_sync u_pin_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(ext_count_pin_i),
        .level_o(ext_level)
    );

    always_comb begin
        s_d = s_q;
        timer_wr = wr_i && (addr_i == tmr_pkg::TIMER_COUNT_ADDR);
        intctl_wr = wr_i && (addr_i == tmr_pkg::INTERRUPT_CONTROL_ADDR);
        option_wr = wr_i && (addr_i == tmr_pkg::OPTION_CONTROL_ADDR);
        to_watchdog = s_q.option_control[tmr_pkg::PRESCALER_ASSIGN_BIT];
        rate = s_q.option_control[tmr_pkg::PRESCALE_RATE_LSB +: tmr_pkg::PRESCALE_RATE_W];

        // Edges are taken only from the synchronised level.
        rise = ext_level && !s_q.ext_prev;
        fall = !ext_level && s_q.ext_prev;
        if (s_q.option_control[tmr_pkg::CLOCK_SOURCE_SELECT_BIT]) begin
            src_tick = s_q.option_control[tmr_pkg::EDGE_POLARITY_BIT] ? fall : rise;
        end else begin
            src_tick = 1'b1;
        end

        // A pending inhibit, sleep or a write in this very cycle stops the timer path.
        gated_tick = src_tick && (s_q.inhibit == 2'h0) && !sleep_i && !timer_wr;

        // Timer ratio is 2^(n+1), watchdog ratio 2^n; the mask is ratio minus one.
        timer_mask = 8'hFF >> (3'h7 - rate);
        watchdog_mask = 8'(9'h0FF >> (4'h8 - {1'h0, rate}));
        pre_mask = to_watchdog ? watchdog_mask : timer_mask;

        // The watchdog keeps running in sleep, so its path ignores sleep_i.
        pre_in = to_watchdog ? watchdog_tick_i : gated_tick;
        // Matching only the selected low bits lets a rate change take effect at once,
        // instead of waiting for the full eight-bit count to roll over.
        pre_wrap = pre_in && ((s_q.prescaler & pre_mask) == pre_mask);
        timer_inc = to_watchdog ? gated_tick : pre_wrap;

        // Clearing on an assignment change avoids a short first period on the new owner.
        pre_clear = (timer_wr && !to_watchdog)
            || (watchdog_clear_instruction_i && to_watchdog)
            || (to_watchdog != s_q.assign_prev);
        if (pre_clear) begin
            s_d.prescaler = 8'h00;
        end else if (pre_in) begin
            s_d.prescaler = pre_wrap ? 8'h00 : s_q.prescaler + 8'h01;
        end
        s_d.assign_prev = to_watchdog;
        s_d.watchdog_post = to_watchdog && pre_wrap && !pre_clear;
        s_d.watchdog_reset = watchdog_clear_instruction_i && to_watchdog;
        s_d.ext_prev = ext_level;

        if (timer_wr) begin
            s_d.inhibit = tmr_pkg::WRITE_INHIBIT_CYCLES;
        end else if (s_q.inhibit != 2'h0) begin
            s_d.inhibit = s_q.inhibit - 2'h1;
        end

        if (timer_wr) begin
            s_d.timer_count = wdata_i[7:0];
        end else if (timer_inc) begin
            s_d.timer_count = s_q.timer_count + 8'h01;
        end

        // The overflow event beats a clear written in the same cycle.
        if (intctl_wr && wdata_i[tmr_pkg::OVERFLOW_FLAG_BIT]) begin
            s_d.overflow_flag = 1'b0;
        end
        if (timer_inc && (s_q.timer_count == tmr_pkg::TIMER_COUNT_MAX)) begin
            s_d.overflow_flag = 1'b1;
        end
        if (intctl_wr) begin
            s_d.overflow_int_enable = wdata_i[tmr_pkg::OVERFLOW_INT_ENABLE_BIT];
        end
        if (option_wr) begin
            s_d.option_control = wdata_i[7:0];
        end

        intctl_view = 8'h00;
        intctl_view[tmr_pkg::OVERFLOW_FLAG_BIT] = s_q.overflow_flag;
        intctl_view[tmr_pkg::OVERFLOW_INT_ENABLE_BIT] = s_q.overflow_int_enable;

        // The prescaler count has no address, so it can never be read or written.
        s_d.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                tmr_pkg::TIMER_COUNT_ADDR: begin
                    s_d.rdata = s_q.timer_count;
                end
                tmr_pkg::INTERRUPT_CONTROL_ADDR: begin
                    s_d.rdata = intctl_view;
                end
                tmr_pkg::OPTION_CONTROL_ADDR: begin
                    s_d.rdata = s_q.option_control;
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.timer_count <= tmr_pkg::TIMER_COUNT_RST;
            s_q.option_control <= tmr_pkg::OPTION_CONTROL_RST;
            s_q.assign_prev <= tmr_pkg::OPTION_CONTROL_RST[tmr_pkg::PRESCALER_ASSIGN_BIT];
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = {24'h000000, s_q.rdata};
    assign irq_o = s_q.overflow_flag && s_q.overflow_int_enable;
    assign watchdog_post_tick_o = s_q.watchdog_post;
    assign watchdog_reset_o = s_q.watchdog_reset;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    write_inhibit_a: assert property (timer_wr |=> !timer_inc ##1 !timer_inc)
        else $error("Timer counted within two cycles of a count write.");

    write_load_a: assert property (timer_wr |=> s_q.timer_count == $past(wdata_i[7:0]))
        else $error("Count write did not load the written value.");

    sleep_stop_a: assert property (sleep_i && !timer_wr |=> $stable(s_q.timer_count))
        else $error("Timer moved during sleep.");

    overflow_set_a: assert property (timer_inc && s_q.timer_count == 8'hFF
        |=> s_q.overflow_flag && s_q.timer_count == 8'h00)
        else $error("Wrap from FFh did not set the flag and reach 00h.");

    flag_sticky_a: assert property (s_q.overflow_flag
        && !(intctl_wr && wdata_i[tmr_pkg::OVERFLOW_FLAG_BIT]) |=> s_q.overflow_flag)
        else $error("Overflow flag dropped without a software clear.");

    irq_gate_a: assert property (timer_inc && s_q.timer_count == tmr_pkg::TIMER_COUNT_MAX
        && s_q.overflow_int_enable && !intctl_wr |=> irq_o)
        else $error("Enabled overflow did not raise the interrupt.");

    timer_mode_a: assert property (!s_q.option_control[tmr_pkg::CLOCK_SOURCE_SELECT_BIT]
        && to_watchdog && !sleep_i && !timer_wr && s_q.inhibit == 2'h0
        |=> s_q.timer_count == $past(s_q.timer_count) + 8'h01)
        else $error("Timer mode without prescaler did not count every cycle.");

    edge_mode_a: assert property (s_q.option_control[tmr_pkg::CLOCK_SOURCE_SELECT_BIT]
        && !src_tick |-> !timer_inc)
        else $error("Counter mode counted without a selected pin edge.");

    pre_write_clear_a: assert property (timer_wr && !to_watchdog |=> s_q.prescaler == 8'h00
        && s_q.option_control == $past(s_q.option_control))
        else $error("Count write did not clear the prescaler or changed the assignment.");

    wdt_clear_a: assert property (watchdog_clear_instruction_i && to_watchdog
        |=> s_q.prescaler == 8'h00 && watchdog_reset_o)
        else $error("Watchdog clear did not reset the prescaler and watchdog.");

    exclusive_use_a: assert property (watchdog_post_tick_o |-> $past(to_watchdog))
        else $error("Watchdog tick while the prescaler served the timer.");

    timer_ratio_a: assert property (!to_watchdog && timer_inc
        |-> (s_q.prescaler & timer_mask) == timer_mask)
        else $error("Timer increment at the wrong prescaler count.");

    wdt_ratio_a: assert property (to_watchdog && pre_in && rate == 3'h0 && !pre_clear
        |=> watchdog_post_tick_o)
        else $error("Watchdog ratio 1:1 did not pass every tick.");

    read_back_a: assert property (rd_i && addr_i == tmr_pkg::TIMER_COUNT_ADDR
        |=> rdata_o == {24'h000000, $past(s_q.timer_count)})
        else $error("Count read returned the wrong value.");

    // The checks below pin down the hold and load behaviour of the count, enable, option and prescaler state,
    // so that a stray enable in the next-state logic shows up at once.
    irq_mask_a: assert property (intctl_wr && !wdata_i[tmr_pkg::OVERFLOW_INT_ENABLE_BIT]
        |=> !irq_o)
        else $error("Interrupt stayed high after its enable was cleared.");

    enable_hold_a: assert property (!intctl_wr
        |=> $stable(s_q.overflow_int_enable))
        else $error("Interrupt enable changed without a write.");

    inhibit_load_a: assert property (timer_wr
        |=> s_q.inhibit == tmr_pkg::WRITE_INHIBIT_CYCLES)
        else $error("Count write did not start the inhibit window.");

    count_hold_a: assert property (!timer_inc && !timer_wr
        |=> $stable(s_q.timer_count))
        else $error("Count moved without an increment or a write.");

    count_step_a: assert property (timer_inc
        |=> s_q.timer_count == $past(s_q.timer_count) + 8'h01)
        else $error("Increment did not add exactly one.");

    flag_clear_a: assert property (intctl_wr && wdata_i[tmr_pkg::OVERFLOW_FLAG_BIT]
        && !(timer_inc && s_q.timer_count == tmr_pkg::TIMER_COUNT_MAX) |=> !s_q.overflow_flag)
        else $error("Writing one to the flag did not clear it.");

    sleep_no_inc_a: assert property (sleep_i
        |-> !timer_inc)
        else $error("Timer incremented during sleep.");

    wdt_idle_a: assert property (!to_watchdog
        |=> !watchdog_post_tick_o)
        else $error("Watchdog tick while the prescaler served the timer.");

    wdt_source_a: assert property (watchdog_post_tick_o
        |-> $past(watchdog_tick_i))
        else $error("Watchdog tick without a base tick.");

    wdt_hold_a: assert property (to_watchdog && !watchdog_tick_i && !pre_clear
        |=> $stable(s_q.prescaler))
        else $error("Watchdog prescaler moved without a base tick.");

    timer_pre_hold_a: assert property (!to_watchdog && !pre_in && !pre_clear
        |=> $stable(s_q.prescaler))
        else $error("Timer prescaler moved without a source tick.");

    pre_step_a: assert property (pre_in && !pre_wrap && !pre_clear
        |=> s_q.prescaler == $past(s_q.prescaler) + 8'h01)
        else $error("Prescaler did not advance by one on a tick.");

    assign_switch_a: assert property (to_watchdog != s_q.assign_prev
        |=> s_q.prescaler == 8'h00)
        else $error("Assignment change did not clear the prescaler.");

    option_load_a: assert property (option_wr
        |=> s_q.option_control == $past(wdata_i[7:0]))
        else $error("Option write did not load the written value.");

    option_hold_a: assert property (!option_wr
        |=> $stable(s_q.option_control))
        else $error("Option register changed without a write.");

    wdt_reset_src_a: assert property (watchdog_reset_o
        |-> $past(watchdog_clear_instruction_i && to_watchdog))
        else $error("Watchdog reset without a clear while assigned.");

    edge_select_a: assert property (s_q.option_control[tmr_pkg::CLOCK_SOURCE_SELECT_BIT]
        && s_q.option_control[tmr_pkg::EDGE_POLARITY_BIT] && rise |-> !src_tick)
        else $error("Falling-edge mode took a rising edge.");

    sync_delay_a: assert property (rise
        |-> $past(ext_count_pin_i, 2))
        else $error("Pin edge used without passing both synchroniser stages.");

    read_option_a: assert property (rd_i && addr_i == tmr_pkg::OPTION_CONTROL_ADDR
        |=> rdata_o == {24'h000000, $past(s_q.option_control)})
        else $error("Option read returned the wrong value.");

    read_intctl_a: assert property (rd_i && addr_i == tmr_pkg::INTERRUPT_CONTROL_ADDR
        |=> rdata_o == {24'h000000, 2'h0, $past(s_q.overflow_int_enable), 2'h0, $past(s_q.overflow_flag), 2'h0})
        else $error("Interrupt control read returned the wrong value.");

    rdata_idle_a: assert property (!rd_i
        |=> rdata_o == 32'h00000000)
        else $error("Read data not zero outside a read.");

    overflow_c: cover property (timer_inc && s_q.timer_count == 8'hFF);

    irq_c: cover property (irq_o);

    edge_count_c: cover property (s_q.option_control[tmr_pkg::CLOCK_SOURCE_SELECT_BIT] && timer_inc);

    watchdog_post_c: cover property (watchdog_post_tick_o && s_q.option_control[2:0] == 3'h2);

    assign_change_c: cover property (to_watchdog != s_q.assign_prev);

endmodule

/* File: hdl/pin_sync.sv */
// Two-stage level synchroniser for an asynchronous input pin.
// Assumes the pin may change at any time relative to clk_i.
`timescale 1ns/100ps

module pin_sync (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic level_o
);

    typedef struct packed {
        logic [tmr_pkg::SYNC_STAGES-1:0] stage;
    } sync_state_type;

    sync_state_type s_q;
    sync_state_type s_d;

    // The first stage feeds only the second one; nothing else looks at it.
    always_comb begin
        s_d = s_q;
        s_d.stage = {s_q.stage[tmr_pkg::SYNC_STAGES-2:0], pin_i};
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.stage[tmr_pkg::SYNC_STAGES-1];

endmodule

/* File: hdl/tmr_pkg.sv */
// Shared constants for the eight-bit timer with its shared prescaler.
// Assumes a word-wide register port whose byte address is four times the register index.
package tmr_pkg;

    // Register indexes and the byte addresses derived from them.
    localparam logic [7:0] TIMER_COUNT_IDX = 8'h01;
    localparam logic [7:0] INTERRUPT_CONTROL_IDX = 8'h0B;
    localparam logic [7:0] OPTION_CONTROL_IDX = 8'h81;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] TIMER_COUNT_ADDR = {TIMER_COUNT_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_ADDR = {INTERRUPT_CONTROL_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] OPTION_CONTROL_ADDR = {OPTION_CONTROL_IDX, 2'h0};

    // Field positions in the interrupt control register.
    localparam int OVERFLOW_FLAG_BIT = 2;
    localparam int OVERFLOW_INT_ENABLE_BIT = 5;

    // Field positions in the option control register.
    localparam int CLOCK_SOURCE_SELECT_BIT = 5;
    localparam int EDGE_POLARITY_BIT = 4;
    localparam int PRESCALER_ASSIGN_BIT = 3;
    localparam int PRESCALE_RATE_LSB = 0;
    localparam int PRESCALE_RATE_W = 3;

    // Values after reset, and the last count before the wrap to 00h.
    localparam logic [7:0] OPTION_CONTROL_RST = 8'hFF;
    localparam logic [7:0] TIMER_COUNT_RST = 8'h00;
    localparam logic [7:0] TIMER_COUNT_MAX = 8'hFF;

    // Instruction cycles in which counting stays suppressed after a count write.
    localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

    // Synchroniser depth on the external count pin.
    localparam int SYNC_STAGES = 2;

endpackage

/* File: verification/eight_bit_timer_prescaler_tb.sv */
// Self-checking bench for the eight-bit timer with its shared prescaler.
// Assumes one clk_i period is one instruction cycle and a count pin from ext_pin_model.
`timescale 1ns/100ps
module eight_bit_timer_prescaler_tb;
    localparam logic [9:0] TC = tmr_pkg::TIMER_COUNT_ADDR;
    localparam logic [9:0] IC = tmr_pkg::INTERRUPT_CONTROL_ADDR;
    localparam logic [9:0] OC = tmr_pkg::OPTION_CONTROL_ADDR;
    logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic slp = 1'b0, tick = 1'b0, clr = 1'b0, go = 1'b0, pin, post, wrst, irq;
    logic [9:0] addr = 10'h000;
    logic [31:0] wdat = 32'h00000000, rdat;
    logic [7:0] v, w;
    int errors = 0, samples_checked = 0, c;
    eight_bit_timer_prescaler dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdat),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdat), .ext_count_pin_i(pin), .sleep_i(slp), .watchdog_tick_i(tick),
        .watchdog_clear_instruction_i(clr), .watchdog_post_tick_o(post), .watchdog_reset_o(wrst), .irq_o(irq));
    ext_pin_model pin_u (.clk_i(clk_i), .go_i(go), .pin_o(pin));
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr <= a;
        wdat <= {24'h000000, d};
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdat[7:0];
    endtask
    task automatic results;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic t_regs;
        rd(OC, v);
        chk(v, 8'hFF);
        rd(IC, v);
        chk(v, 8'h00);
        rd(TC, v);
        chk(v, 8'h00);
        @(posedge clk_i);
        #1;
        chk(rdat, 32'h00000000);
        wr(10'h3FC, 8'hFF);
        rd(10'h3FC, v);
        chk(v, 8'h00);
    endtask
    task automatic t_timer;
        wr(OC, 8'h08);
        wr(TC, 8'hFE);
        rd(TC, v);
        chk(v, 8'hFE);
        rd(TC, v);
        chk(v, 8'hFF);
        rd(TC, v);
        chk(v, 8'h01);
        rd(IC, v);
        chk(v, 8'h04);
        chk(irq, 1'b0);
        wr(IC, 8'h04);
        rd(IC, v);
        chk(v, 8'h00);
        wr(IC, 8'h20);
        chk(irq, 1'b0);
        wr(TC, 8'hFD);
        repeat (4) @(posedge clk_i);
        #1;
        chk(irq, 1'b0);
        @(posedge clk_i);
        #1;
        chk(irq, 1'b1);
        wr(IC, 8'h04);
        chk(irq, 1'b0);
        wr(TC, 8'hFD);
        repeat (6) @(posedge clk_i);
        rd(IC, v);
        chk(v, 8'h04);
        chk(irq, 1'b0);
    endtask
    // Two reads 4r cycles apart differ by four whatever phase the prescaler was in.
    task automatic t_presc;
        for (int n = 0; n < 8; n++) begin
            wr(OC, 8'(n));
            wr(TC, 8'h00);
            rd(OC, v);
            chk(v, n);
            rd(TC, v);
            repeat ((8 << n) - 2) @(posedge clk_i);
            rd(TC, w);
            chk(8'(w - v), 8'h04);
        end
    endtask
    task automatic t_wdog;
        for (int n = 0; n < 8; n++) begin
            wr(OC, 8'(8 + n));
            @(posedge clk_i);
            clr <= 1'b1;
            @(posedge clk_i);
            clr <= 1'b0;
            #1;
            chk(wrst, 1'b1);
            c = 0;
            for (int i = 0; i < (4 << n) + 3; i++) begin
                @(posedge clk_i);
                tick <= i < (4 << n);
                #1;
                c += int'(post === 1'b1);
            end
            chk(c, 4);
        end
    endtask
    // The burst lasts forty cycles; the margin covers the pin synchroniser.
    task automatic t_count;
        for (int p = 0; p < 2; p++) begin
            wr(OC, p == 0 ? 8'h28 : 8'h38);
            wr(TC, 8'h00);
            @(posedge clk_i);
            go <= 1'b1;
            @(posedge clk_i);
            go <= 1'b0;
            repeat (50) @(posedge clk_i);
            rd(TC, v);
            chk(v, 8'h05);
        end
    endtask
    task automatic t_sleep;
        wr(OC, 8'h08);
        @(posedge clk_i);
        slp <= 1'b1;
        rd(TC, v);
        repeat (20) @(posedge clk_i);
        rd(TC, w);
        chk(w, v);
        @(posedge clk_i);
        slp <= 1'b0;
        rd(TC, w);
        chk(w, 8'(v + 8'h01));
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_timer();
        t_presc();
        t_wdog();
        t_count();
        t_sleep();
        results();
    end
endmodule

/* File: verification/ext_pin_model.sv */
// Model of the external count pin: one burst of five square pulses for each go_i pulse.
// Assumes go_i is one clk_i cycle long; the pin rests low so no stray edge appears at reset.
`timescale 1ns/100ps
module ext_pin_model (
    input wire logic clk_i,
    input wire logic go_i,
    output logic pin_o
);
    logic [3:0] left_q = 4'h0;
    logic [1:0] ph_q = 2'h0;
    logic pin_q = 1'b0;
    assign pin_o = pin_q;
    always @(posedge clk_i) begin
        ph_q <= ph_q + 2'h1;
        if (go_i) begin
            left_q <= 4'hA;
        end else if (left_q != 4'h0 && ph_q == 2'h3) begin
            pin_q <= ~pin_q;
            left_q <= left_q - 4'h1;
        end
    end
endmodule
